// ### rtl/stage_handshake.sv
// first-stage pattern detector, ready countdown and live gating of core inputs
// Functional notes
// - pattern pair 0x12/0x9A, parameterised, shared
// - detect alternation, then start countdown
// - countdown end asserts application-ready output
// - live means stage two loaded, interaction allowed
// - done pulses after stage one, stays high later
// - only system reset needed in stage one
// - shared bank outputs undefined until stage two
// - critical inputs held deasserted until live; the code holds them at the crit_idle input value instead
`timescale 1ns/1ps
`default_nettype none
module stage_handshake
  import stage_handshake_pkg::*;
#(
  parameter logic [7:0]  FIRST_VALUE  = FIRST_PATTERN_VALUE,
  parameter logic [7:0]  SECOND_VALUE = SECOND_PATTERN_VALUE,
  parameter logic [15:0] COUNTDOWN    = 16'(COUNTDOWN_CYCLES),
  parameter int          CRIT_WIDTH   = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            pattern_bus,
  input  wire logic                  stage_one_startup,
  input  wire logic                  stage_two_startup,
  input  wire logic [CRIT_WIDTH-1:0] crit_user_in,
  input  wire logic [CRIT_WIDTH-1:0] crit_idle,
  output logic [CRIT_WIDTH-1:0]      crit_core_in,
  output handshake_status_s          status,
  output logic                       bank_connected
);
  logic             rst_meta;
  logic             rst_sync;
  handshake_state_s cur;
  handshake_state_s next_cur;
  logic             is_pattern;
  logic             alternates;

  // reset release through two flops; only system reset needed in stage one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // pattern arrives already in this clock's domain
  assign is_pattern = (pattern_bus == FIRST_VALUE) || (pattern_bus == SECOND_VALUE);
  assign alternates = is_pattern && cur.prev_valid && (pattern_bus != cur.prev_pattern);

  always_comb begin
    next_cur              = cur;
    next_cur.prev_pattern = pattern_bus;
    next_cur.prev_valid   = is_pattern;
    // pin pulses while stage one starts up, then stays high once stage two is done
    next_cur.done_pulse   = stage_one_startup && !cur.stage_two_done;
    if (stage_two_startup) begin
      next_cur.stage_two_done = 1'b1;
    end
    unique case (cur.state)
      // count loads on the first alternating pair of samples
      ST_WATCH: begin
        if (alternates) begin
          next_cur.state = ST_COUNT;
          next_cur.count = COUNTDOWN;
        end
      end
      ST_COUNT: begin
        // a repeat or a foreign value drops back to watching
        if (!alternates) begin
          next_cur.state = ST_WATCH;
          next_cur.count = COUNT_ZERO;
        end else if (cur.count == COUNT_ONE) begin
          next_cur.state     = ST_READY;
          next_cur.count     = COUNT_ZERO;
          next_cur.app_ready = 1'b1;
        end else begin
          next_cur.count = cur.count - COUNT_ONE;
        end
      end
      ST_READY: begin
        next_cur.app_ready = 1'b1;
      end
    endcase
    // live follows application-ready one cycle later
    next_cur.live = cur.app_ready;
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cur <= '{
        prev_pattern:   PATTERN_RESET_VALUE,
        prev_valid:     1'b0,
        state:          ST_WATCH,
        count:          COUNT_ZERO,
        app_ready:      1'b0,
        live:           1'b0,
        done_pulse:     1'b0,
        stage_two_done: 1'b0
      };
    end else begin
      cur <= next_cur;
    end
  end

  // critical inputs masked until live
  assign crit_core_in       = cur.live ? crit_user_in : crit_idle;
  assign status = '{
    app_ready:   cur.app_ready,
    live:        cur.live,
    config_done: cur.done_pulse || cur.stage_two_done
  };
  // shared bank pins float internally until stage two completes
  assign bank_connected     = cur.stage_two_done;

  AST_START_COUNT: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_WATCH && alternates) |=> (cur.state == ST_COUNT && cur.count == COUNTDOWN))
    else $error("countdown did not start on alternation");
  AST_READY_AFTER_COUNT: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_COUNT && alternates && cur.count == COUNT_ONE) |=> cur.app_ready)
    else $error("ready missing at countdown end");
  AST_NO_EARLY_READY: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(cur.app_ready) |-> $past(cur.state) == ST_COUNT)
    else $error("ready rose outside countdown");
  AST_BREAK_RESTARTS: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_COUNT && !alternates) |=> cur.state == ST_WATCH)
    else $error("alternation break did not restart");
  AST_LIVE_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(cur.app_ready) |=> cur.live)
    else $error("live did not follow ready");
  AST_MASK: assert property (@(posedge clk) disable iff (!rst_sync)
    !cur.live |-> crit_core_in == crit_idle)
    else $error("critical inputs passed before live");
  AST_READY_STICKS: assert property (@(posedge clk) disable iff (!rst_sync)
    cur.app_ready |=> cur.app_ready)
    else $error("ready dropped");
  AST_DONE_HOLDS: assert property (@(posedge clk) disable iff (!rst_sync)
    stage_two_startup |=> status.config_done [*2])
    else $error("done not held after stage two");
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_sync)
    (stage_one_startup && !cur.stage_two_done && !stage_two_startup) |=> status.config_done)
    else $error("done pulse missing");

  // state and countdown bookkeeping
  AST_STATE_ONEHOT: assert property (@(posedge clk) disable iff (!rst_sync)
    $onehot(cur.state))
    else $error("state code not one-hot");
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_COUNT && alternates && cur.count != COUNT_ONE) |=>
      (cur.state == ST_COUNT && cur.count == $past(cur.count) - COUNT_ONE))
    else $error("countdown did not step by one");
  AST_COUNT_BOUND: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_COUNT) |-> (cur.count != COUNT_ZERO && cur.count <= COUNTDOWN))
    else $error("countdown out of range");
  AST_COUNT_IDLE_ZERO: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state != ST_COUNT) |-> (cur.count == COUNT_ZERO))
    else $error("count left over outside countdown");
  AST_REPEAT_NO_START: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_WATCH && pattern_bus == cur.prev_pattern) |=> cur.state == ST_WATCH)
    else $error("repeated value started countdown");
  AST_OTHER_VALUE_NO_START: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_WATCH && pattern_bus != FIRST_VALUE && pattern_bus != SECOND_VALUE) |=> cur.state == ST_WATCH)
    else $error("foreign value started countdown");

  // ready, live and the input gate
  AST_WATCH_NOT_READY: assert property (@(posedge clk) disable iff (!rst_sync)
    (cur.state == ST_WATCH) |-> !cur.app_ready)
    else $error("ready while watching");
  AST_READY_STATE: assert property (@(posedge clk) disable iff (!rst_sync)
    cur.app_ready |-> cur.state == ST_READY)
    else $error("ready outside ready state");
  AST_READY_NEEDS_COUNT: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(cur.app_ready) |-> ($past(cur.count) == COUNT_ONE && $past(alternates)))
    else $error("ready without finished countdown");
  AST_LIVE_LAG: assert property (@(posedge clk) disable iff (!rst_sync)
    cur.live == $past(cur.app_ready))
    else $error("live not one cycle behind ready");
  AST_LIVE_NEEDS_READY: assert property (@(posedge clk) disable iff (!rst_sync)
    cur.live |-> cur.app_ready)
    else $error("live without ready");
  AST_LIVE_STICKS: assert property (@(posedge clk) disable iff (!rst_sync)
    cur.live |=> cur.live)
    else $error("live dropped");
  AST_PASS_AFTER_READY: assert property (@(posedge clk) disable iff (!rst_sync)
    $past(cur.app_ready) |-> crit_core_in == crit_user_in)
    else $error("critical inputs still masked after live");

  // done pin and shared bank
  AST_DONE_PULSE_ENDS: assert property (@(posedge clk) disable iff (!rst_sync)
    (!stage_one_startup && !stage_two_startup && !cur.stage_two_done) |=> !status.config_done)
    else $error("done pulse too long");
  AST_BANK_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_sync)
    stage_two_startup |=> bank_connected)
    else $error("bank not connected after stage two");
  AST_BANK_EARLY: assert property (@(posedge clk) disable iff (!rst_sync)
    (!stage_two_startup && !bank_connected) |=> !bank_connected)
    else $error("bank connected before stage two");

  // state seen on the first edge after reset release
  AST_RESET_CLEAN: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(rst_sync) |-> (cur.state == ST_WATCH && !cur.app_ready && !cur.live && !cur.stage_two_done))
    else $error("state not clear after reset");
  AST_RESET_MASKED: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(rst_sync) |-> (crit_core_in == crit_idle && !bank_connected))
    else $error("outputs not idle after reset");

  COV_DETECT: cover property (@(posedge clk) disable iff (!rst_sync) cur.state == ST_COUNT);
  COV_READY: cover property (@(posedge clk) disable iff (!rst_sync) $rose(cur.live));
  COV_BREAK: cover property (@(posedge clk) disable iff (!rst_sync) cur.state == ST_COUNT && !alternates);
  COV_DONE: cover property (@(posedge clk) disable iff (!rst_sync) $rose(cur.stage_two_done));
  COV_REPEAT: cover property (@(posedge clk) disable iff (!rst_sync) is_pattern && pattern_bus == cur.prev_pattern);
endmodule
`default_nettype wire

// ### include/stage_handshake_pkg.sv
// shared constants and carrier types for the two-stage ready handshake
package stage_handshake_pkg;
  localparam int          PATTERN_WIDTH       = 8;
  localparam logic [7:0]  FIRST_PATTERN_VALUE  = 8'h12;
  localparam logic [7:0]  SECOND_PATTERN_VALUE = 8'h9A;
  localparam logic [7:0]  PATTERN_RESET_VALUE  = 8'h00;
  localparam int          COUNTDOWN_CYCLES     = 16;
  localparam int          COUNT_WIDTH          = 16;
  localparam logic [15:0] COUNT_ZERO           = 16'h0000;
  localparam logic [15:0] COUNT_ONE            = 16'h0001;

  typedef enum logic [2:0] {
    ST_WATCH = 3'b001,
    ST_COUNT = 3'b010,
    ST_READY = 3'b100
  } ready_state_e;

  typedef struct packed {
    logic [7:0]  prev_pattern;
    logic        prev_valid;
    ready_state_e state;
    logic [15:0] count;
    logic        app_ready;
    logic        live;
    logic        done_pulse;
    logic        stage_two_done;
  } handshake_state_s;

  typedef struct packed {
    logic app_ready;
    logic live;
    logic config_done;
  } handshake_status_s;
endpackage

// ### testbench/pattern_source.sv
// second-stage pattern source with two pipeline registers
`timescale 1ns/1ps
`default_nettype none
module pattern_source
  import stage_handshake_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  run,
  input  wire logic  hold,
  output logic [7:0] pattern
);
  logic       sel;
  logic [7:0] gen;
  logic [7:0] stage1;
  // all flops take the system reset, none relies on the shared bank
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel     <= 1'b0;
      gen     <= PATTERN_RESET_VALUE;
      stage1  <= PATTERN_RESET_VALUE;
      pattern <= PATTERN_RESET_VALUE;
    end else begin
      // hold repeats one value to break alternation
      if (run && !hold) sel <= ~sel;
      gen     <= run ? (sel ? SECOND_PATTERN_VALUE : FIRST_PATTERN_VALUE) : PATTERN_RESET_VALUE;
      stage1  <= gen;
      pattern <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/test_two_stage_ready_handshake.sv
// self-checking bench for the two-stage ready handshake
`timescale 1ns/1ps
`default_nettype none
module test_two_stage_ready_handshake;
  import stage_handshake_pkg::*;
  localparam int CD = 5;
  logic clk, rstn, s1, s2, run, hold, bank;
  logic [7:0] pat;
  logic [3:0] user_in, idle, core_in;
  handshake_status_s st;
  int bad_count, cmp_count, n;
  // rows: stage one start, stage two start, expected done pin, expected bank
  logic [3:0] rows [4] = '{4'b1010, 4'b0000, 4'b0111, 4'b0011};
  pattern_source ps (.clk(clk), .rstn(rstn), .run(run), .hold(hold), .pattern(pat));
  stage_handshake #(.COUNTDOWN(16'(CD))) uut (.clk(clk), .rstn(rstn), .pattern_bus(pat), .stage_one_startup(s1),
    .stage_two_startup(s2), .crit_user_in(user_in), .crit_idle(idle), .crit_core_in(core_in), .status(st),
    .bank_connected(bank));
  task automatic chk1(string what, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic chk4(string what, logic [3:0] exp, logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0; s1 = 1'b0; s2 = 1'b0; run = 1'b0; hold = 1'b0;
    user_in = 4'hA; idle = 4'h5; bad_count = 0; cmp_count = 0;
    repeat (5) @(negedge clk);
    chk4("mux in reset", idle, core_in);
    chk1("ready in reset", 1'b0, st.app_ready);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      {s1, s2} = rows[i][3:2];
      @(negedge clk);
      chk1("config_done", rows[i][1], st.config_done);
      chk1("bank_connected", rows[i][0], bank);
    end
    // pattern starts only once stage two has started up
    run = 1'b1;
    repeat (CD) @(negedge clk);
    hold = 1'b1;
    @(negedge clk);
    hold = 1'b0;
    n = 0;
    while (st.app_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk1("restart window", 1'b1, logic'(n >= CD + 2 && n <= CD + 10));
    if (n >= 60) end_sim();
    chk1("live lags ready", 1'b0, st.live);
    chk4("mux before live", idle, core_in);
    @(negedge clk);
    chk1("live", 1'b1, st.live);
    chk4("mux after live", user_in, core_in);
    user_in = 4'h3;
    hold = 1'b1;
    #1;
    chk4("mux follows user", 4'h3, core_in);
    repeat (3) @(negedge clk);
    chk1("ready sticky", 1'b1, st.app_ready);
    rstn = 1'b0;
    @(negedge clk);
    chk1("ready cleared", 1'b0, st.app_ready);
    chk4("mux idle again", idle, core_in);
    // mid-run release with the source held: a constant value never alternates
    rstn = 1'b1;
    repeat (20) @(negedge clk);
    chk1("no ready on repeat", 1'b0, st.app_ready);
    chk1("bank after reset", 1'b0, bank);
    chk1("done after reset", 1'b0, st.config_done);
    hold = 1'b0;
    n = 0;
    while (st.app_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    // generator flop, two pipeline stages, first pair, then the countdown
    chk1("ready after release", 1'b1, logic'(n == CD + 5));
    end_sim();
  end
endmodule
`default_nettype wire
